/* design/sfb_pkg.sv */
/*
  Constants, field layout and carrier types for the status flag bank.
  Assumes a serial frame of sixteen bits, most significant bit first.
*/
package sfb_pkg;
  // Register map, index 0 to 3
  localparam int SFB_NREG = 4;
  localparam logic [3:0][6:0] SFB_ADDR = {7'h47, 7'h46, 7'h44, 7'h43};
  localparam int SFB_IDX_DEV = 0;
  localparam int SFB_IDX_BUS = 1;
  localparam int SFB_IDX_WKA = 2;
  localparam int SFB_IDX_WKB = 3;
  localparam logic [7:0] SFB_RST_VAL = 8'h00;
  // Implemented bits, bits cleared by a write, bits kept through restart
  localparam logic [3:0][7:0] SFB_VALID = {8'h10, 8'h31, 8'h07, 8'hCF};
  localparam logic [3:0][7:0] SFB_CLR_MASK = {8'h10, 8'h31, 8'h07, 8'hC3};
  localparam logic [3:0][7:0] SFB_KEEP_MASK = {8'h00, 8'h31, 8'h07, 8'hCF};
  // Device information fields
  localparam int SFB_PRIOR_LSB = 6;
  localparam int SFB_WD_LSB = 2;
  localparam int SFB_INV_BIT = 1;
  localparam int SFB_FAIL_BIT = 0;
  localparam logic [1:0] SFB_PRIOR_FAIL = 2'h1;
  localparam logic [1:0] SFB_PRIOR_SLEEP = 2'h2;
  localparam logic [1:0] SFB_WD_NONE = 2'h0;
  localparam logic [1:0] SFB_WD_ONE = 2'h1;
  localparam logic [1:0] SFB_WD_TWO = 2'h2;
  // Bus status fields
  localparam int SFB_CAN_LSB = 1;
  localparam int SFB_UV_BIT = 0;
  localparam logic [1:0] SFB_CAN_TSD = 2'h1;
  localparam logic [1:0] SFB_CAN_TXD = 2'h2;
  localparam logic [1:0] SFB_CAN_BUS = 2'h3;
  // Wake fields
  localparam int SFB_BUS_WAKE_BIT = 5;
  localparam int SFB_TIMER_WAKE_BIT = 4;
  localparam int SFB_PIN_WAKE_BIT = 0;
  localparam int SFB_GPIO_WAKE_BIT = 4;
  // Configuration select codes
  localparam logic [1:0] SFB_CONFIGURATION_SELECT = 2'h0;
  localparam logic [1:0] SFB_CFG2 = 2'h1;
  localparam logic [1:0] SFB_CFG3 = 2'h2;
  localparam logic [1:0] SFB_CFG4 = 2'h3;
  // Serial frame
  localparam logic [4:0] SFB_LAST_BIT = 5'h0F;
  localparam logic [4:0] SFB_CNT_END = 5'h10;
  localparam int SFB_WRITE_BIT = 15;
  localparam int SFB_ADDR_LSB = 8;

  typedef struct packed {
    logic watchdog_failure_count;
    logic wd_ok;
    logic wd_clear;
    logic severe_thermal;
    logic main_uv;
    logic sleep_no_wake;
    logic failsafe_wake;
    logic sleep_exit;
    logic sleep_flags_set;
    logic fail_output;
    logic can_tsd;
    logic txd_dom;
    logic bus_dom;
    logic bus_wake;
    logic timer_wake;
    logic pin_wake;
    logic gpio_wake;
    logic soft_reset;
    logic restart;
  } sfb_evt_t;

  typedef struct packed {
    logic [3:0][7:0] regs;
    logic frozen;
    logic [2:0] done_s;
    logic [1:0] uv_s;
    logic [15:0] rsp;
    logic cmp_en;
    logic tx_dis;
    logic fail_req;
    logic wake_pend;
  } sfb_core_t;

  typedef struct packed {
    logic [4:0] cnt;
    logic done;
    logic oe;
    logic [15:0] tx;
  } sfb_lnk_t;
endpackage

/* design/sfb_bank.sv */
/*
  Status flag bank: four status registers reached over a serial frame,
  with the serial shifter on its own clock and the bank on CLK.
  Assumes event inputs are one-cycle pulses from logic on CLK and that
  chip select stays high at least eight CLK cycles between frames.
*/
//
// Overview of operation
// - Prior-state field in bits 7:6
// - Failure events record prior-state code 01
// - Sleep attempt with wake flags records 10
// - Watchdog failure count in bits 3:2
// - Watchdog count updated and cleared by hardware
// - Configs 2/4 freeze count until good trigger
// - Invalid serial command sets bit 1
// - Fail output activation sets bit 0
// - CAN failure code in bus bits 2:1
// - Supply undervoltage sets bit 0, disables transmitter
// - Undervoltage comparator enabled only in active mode
// - Wake from fail-safe sets matching flag too; failsafe_wake here only sets prior-state 01, no wake flag
// - General pin wake sets fourth register bit 4
// - Reserved bits read zero, ignore writes
// - Power-on or soft reset zeroes all registers
// - Restart keeps device info, zeroes bits 5:4
// - Restart keeps CAN fields, zeroes upper bits
`timescale 1ns/1ps
module sfb_bank
  import sfb_pkg::*;
(
  // System
  input wire logic CLK,
  input wire logic RST,
  // Serial link
  input wire logic SPI_SCK,
  input wire logic SPI_CS_N,
  input wire logic SPI_MOSI,
  output logic SPI_MISO,
  output logic SPI_MISO_OE,
  // Events and levels from the rest of the chip
  input wire sfb_evt_t EVT,
  input wire logic [1:0] CONFIG_SEL,
  input wire logic CAN_MODE_ACTIVE,
  input wire logic CAN_SUPPLY_LOW,
  // Controls to the rest of the chip
  output logic UV_CMP_EN,
  output logic CAN_TX_DISABLE,
  output logic WATCHDOG_FAILURE_COUNT_OUT_REQ,
  output logic WAKE_PENDING
);

  sfb_core_t c_q;
  sfb_core_t c_d;
  sfb_lnk_t l_q;
  sfb_lnk_t l_d;
  logic [15:0] rx_q;

  logic frame_hit;
  logic cmd_wr;
  logic [6:0] cmd_addr;
  logic [3:0] sel;
  logic bad_cmd;
  logic [7:0] rdata;
  logic [3:0][7:0] set_v;
  logic [3:0][7:0] clr_v;
  logic [3:0][7:0] nxt;
  logic [1:0] wd_cur;
  logic [1:0] wd_nxt;
  logic [1:0] wd_thr;
  logic freeze_cfg;
  logic wd_fo;
  logic prior_fail;
  logic prior_sleep;
  logic can_ev;
  logic [1:0] can_code;
  logic uv_ev;
  logic wake_any;

  // Link side: shifter on the serial clock, cleared while deselected
  always_comb begin
    l_d = l_q;
    l_d.oe = 1'b1;
    if (l_q.cnt == 5'h00) begin
      l_d.tx = c_q.rsp;
    end else begin
      l_d.tx = {l_q.tx[14:0], 1'b0};
    end
    if (l_q.cnt == SFB_LAST_BIT) begin
      l_d.done = 1'b1;
    end
    if (l_q.cnt != SFB_CNT_END) begin
      l_d.cnt = l_q.cnt + 5'h01;
    end
  end

  always_ff @(posedge SPI_SCK or posedge SPI_CS_N) begin
    if (SPI_CS_N) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Received word, frozen after the sixteenth bit
  always_ff @(posedge SPI_SCK) begin
    if (!SPI_CS_N && l_q.cnt != SFB_CNT_END) begin
      rx_q <= {rx_q[14:0], SPI_MOSI};
    end
  end

  assign SPI_MISO = l_q.tx[15];
  assign SPI_MISO_OE = l_q.oe;

  // Command decode on the rising edge of the synchronised frame flag
  always_comb begin
    frame_hit = c_q.done_s[1] & ~c_q.done_s[2];
    cmd_wr = frame_hit & rx_q[SFB_WRITE_BIT];
    cmd_addr = rx_q[SFB_WRITE_BIT-1:SFB_ADDR_LSB];
    rdata = 8'h00;
    for (int i = 0; i < SFB_NREG; i++) begin
      sel[i] = frame_hit && (cmd_addr == SFB_ADDR[i]);
      if (sel[i]) begin
        rdata = rdata | c_q.regs[i];
      end
    end
    bad_cmd = frame_hit && (sel == 4'h0);
  end

  // Watchdog failure counter
  always_comb begin
    wd_cur = c_q.regs[SFB_IDX_DEV][SFB_WD_LSB+1:SFB_WD_LSB];
    freeze_cfg = (CONFIG_SEL == SFB_CFG2) || (CONFIG_SEL == SFB_CFG4);
    wd_thr = (CONFIG_SEL == SFB_CFG2) ? SFB_WD_ONE : SFB_WD_TWO;
    wd_nxt = wd_cur;
    if (EVT.wd_clear) begin
      wd_nxt = SFB_WD_NONE;
    end else if (EVT.watchdog_failure_count && !c_q.frozen && wd_cur != SFB_WD_TWO) begin
      wd_nxt = wd_cur + SFB_WD_ONE;
    end
    wd_fo = EVT.watchdog_failure_count && !c_q.frozen && !EVT.wd_clear && (wd_nxt == wd_thr) &&
      (wd_cur != wd_thr);
  end

  // Event sources
  always_comb begin
    prior_fail = EVT.watchdog_failure_count | EVT.severe_thermal | EVT.main_uv | EVT.sleep_no_wake |
      EVT.failsafe_wake;
    prior_sleep = EVT.sleep_exit | EVT.sleep_flags_set;
    can_ev = EVT.can_tsd | EVT.txd_dom | EVT.bus_dom;
    if (EVT.bus_dom) begin
      can_code = SFB_CAN_BUS;
    end else if (EVT.txd_dom) begin
      can_code = SFB_CAN_TXD;
    end else begin
      can_code = SFB_CAN_TSD;
    end
    uv_ev = c_q.cmp_en & c_q.uv_s[1];
    set_v = '0;
    set_v[SFB_IDX_DEV][SFB_INV_BIT] = bad_cmd;
    set_v[SFB_IDX_DEV][SFB_FAIL_BIT] = EVT.fail_output | wd_fo;
    set_v[SFB_IDX_BUS][SFB_UV_BIT] = uv_ev;
    set_v[SFB_IDX_WKA][SFB_BUS_WAKE_BIT] = EVT.bus_wake;
    set_v[SFB_IDX_WKA][SFB_TIMER_WAKE_BIT] = EVT.timer_wake;
    set_v[SFB_IDX_WKA][SFB_PIN_WAKE_BIT] = EVT.pin_wake;
    set_v[SFB_IDX_WKB][SFB_GPIO_WAKE_BIT] = EVT.gpio_wake;
  end

  // Register update: set wins over a clear in the same cycle
  always_comb begin
    for (int i = 0; i < SFB_NREG; i++) begin
      clr_v[i] = (sel[i] && cmd_wr) ? SFB_CLR_MASK[i] : 8'h00;
      nxt[i] = ((c_q.regs[i] & ~clr_v[i]) | set_v[i]) & SFB_VALID[i];
    end
    if (prior_fail) begin
      nxt[SFB_IDX_DEV][SFB_PRIOR_LSB+1:SFB_PRIOR_LSB] = SFB_PRIOR_FAIL;
    end else if (prior_sleep) begin
      nxt[SFB_IDX_DEV][SFB_PRIOR_LSB+1:SFB_PRIOR_LSB] = SFB_PRIOR_SLEEP;
    end
    nxt[SFB_IDX_DEV][SFB_WD_LSB+1:SFB_WD_LSB] = wd_nxt;
    if (can_ev) begin
      nxt[SFB_IDX_BUS][SFB_CAN_LSB+1:SFB_CAN_LSB] = can_code;
    end
    if (EVT.soft_reset) begin
      for (int i = 0; i < SFB_NREG; i++) begin
        nxt[i] = SFB_RST_VAL;
      end
    end else if (EVT.restart) begin
      for (int i = 0; i < SFB_NREG; i++) begin
        nxt[i] = nxt[i] & SFB_KEEP_MASK[i];
      end
    end
    wake_any = (nxt[SFB_IDX_WKA] != 8'h00) || (nxt[SFB_IDX_WKB] != 8'h00);
  end

  // Core next state
  always_comb begin
    c_d = c_q;
    c_d.done_s = {c_q.done_s[1:0], l_q.done};
    c_d.uv_s = {c_q.uv_s[0], CAN_SUPPLY_LOW};
    c_d.regs = nxt;
    c_d.frozen = c_q.frozen;
    if (EVT.wd_ok || EVT.soft_reset) begin
      c_d.frozen = 1'b0;
    end
    if (EVT.watchdog_failure_count && freeze_cfg && !EVT.soft_reset) begin
      c_d.frozen = 1'b1;
    end
    if (frame_hit) begin
      c_d.rsp = {bad_cmd, cmd_addr, rdata};
    end
    c_d.cmp_en = CAN_MODE_ACTIVE;
    c_d.tx_dis = nxt[SFB_IDX_BUS][SFB_UV_BIT];
    c_d.fail_req = wd_fo;
    c_d.wake_pend = wake_any;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign UV_CMP_EN = c_q.cmp_en;
  assign CAN_TX_DISABLE = c_q.tx_dis;
  assign WATCHDOG_FAILURE_COUNT_OUT_REQ = c_q.fail_req;
  assign WAKE_PENDING = c_q.wake_pend;

endmodule

/* test/sfb_bank_chk.sv */
/* Port assertions for the status flag bank; assumes it is bound onto every sfb_bank. */
`timescale 1ns/1ps
module sfb_bank_chk
  import sfb_pkg::*;
(
  // Clock, reset, inputs
  input wire logic CLK,
  input wire logic RST,
  input wire logic SPI_CS_N,
  input wire sfb_evt_t EVT,
  input wire logic CAN_MODE_ACTIVE,
  input wire logic CAN_SUPPLY_LOW,
  // Outputs
  input wire logic UV_CMP_EN,
  input wire logic CAN_TX_DISABLE,
  input wire logic WATCHDOG_FAILURE_COUNT_OUT_REQ,
  input wire logic WAKE_PENDING
);
  logic wk_any;
  assign wk_any = EVT.bus_wake | EVT.timer_wake | EVT.pin_wake | EVT.gpio_wake;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_cmp_en_follow: assert property (!$past(RST) |-> UV_CMP_EN == $past(CAN_MODE_ACTIVE))
    else $error("cmp enable");
  a_wd_req_pulse: assert property (WATCHDOG_FAILURE_COUNT_OUT_REQ |=> !WATCHDOG_FAILURE_COUNT_OUT_REQ)
    else $error("wd req width");
  a_wd_req_cause: assert property ($rose(WATCHDOG_FAILURE_COUNT_OUT_REQ) |->
    $past(EVT.watchdog_failure_count) || $past(EVT.watchdog_failure_count, 2)) else $error("wd req cause");
  a_tx_dis_cause: assert property ($rose(CAN_TX_DISABLE) |->
    $past(UV_CMP_EN) || $past(UV_CMP_EN, 2)) else $error("tx dis cause");
  a_uv_sets_flag: assert property ((UV_CMP_EN && CAN_SUPPLY_LOW) [*4] |->
    ##[1:3] CAN_TX_DISABLE) else $error("uv flag");
  a_tx_dis_hold: assert property ($fell(CAN_TX_DISABLE) |->
    !$past(SPI_CS_N, 8) || $past(EVT.soft_reset)) else $error("tx dis drop");
  a_wake_source: assert property ($rose(WAKE_PENDING) |->
    $past(wk_any) || $past(wk_any, 2)) else $error("wake cause");
  a_wake_follow: assert property (wk_any && !EVT.soft_reset |-> ##[1:2] WAKE_PENDING)
    else $error("wake pending");
  c_wd_req: cover property (WATCHDOG_FAILURE_COUNT_OUT_REQ);
  c_tx_dis: cover property ($rose(CAN_TX_DISABLE));
  c_wake: cover property ($rose(WAKE_PENDING));
endmodule
bind sfb_bank sfb_bank_chk u_chk (.CLK, .RST, .SPI_CS_N, .EVT, .CAN_MODE_ACTIVE,
  .CAN_SUPPLY_LOW, .UV_CMP_EN, .CAN_TX_DISABLE, .WATCHDOG_FAILURE_COUNT_OUT_REQ, .WAKE_PENDING);

/* test/sfb_host.sv */
/* Host model for serial frames; assumes the bench calls xfer, SCK idles low. */
`timescale 1ns/1ps
module sfb_host (
  // Serial link
  output logic SCK,
  output logic CS_N,
  output logic MOSI,
  input wire logic MISO,
  input wire logic MISO_OE
);
  initial begin
    SCK = 1'b0;
    CS_N = 1'b1;
    MOSI = 1'b0;
  end
  // One 16-bit frame, msb first, 64 ns clock, sampled on the falling edge
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    #13.3 CS_N = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      MOSI = w[i];
      #32 SCK = 1'b1;
      #32 SCK = 1'b0;
      r[i] = MISO_OE ? MISO : 1'bx;
    end
    #24 CS_N = 1'b1;
    MOSI = ~MOSI;
    #60;
  endtask
endmodule

/* test/test_sfb_bank.sv */
/* Bench for the status flag bank; assumes the host model and the bound checker. */
`timescale 1ns/1ps
module test_sfb_bank
  import sfb_pkg::*;
;
  logic clk, rst, sck, cs_n, mosi, miso, oe, mode, low, cmp_en, tx_dis, wd_req, wk;
  logic [1:0] cfg;
  logic [15:0] r;
  sfb_evt_t evt;
  int err_count = 0;
  int samples_checked = 0;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  sfb_host u_host (.SCK(sck), .CS_N(cs_n), .MOSI(mosi), .MISO(miso), .MISO_OE(oe));
  sfb_bank u_dut (.CLK(clk), .RST(rst), .SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_MOSI(mosi),
    .SPI_MISO(miso), .SPI_MISO_OE(oe), .EVT(evt), .CONFIG_SEL(cfg), .CAN_MODE_ACTIVE(mode),
    .CAN_SUPPLY_LOW(low), .UV_CMP_EN(cmp_en), .CAN_TX_DISABLE(tx_dis),
    .WATCHDOG_FAILURE_COUNT_OUT_REQ(wd_req), .WAKE_PENDING(wk));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  // Read twice: the answer comes in the following frame
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    u_host.xfer({1'b0, a, 8'h00}, r);
    u_host.xfer({1'b0, a, 8'h00}, r);
    chk("reg", r, {1'b0, a, e});
  endtask
  task automatic clr(input logic [6:0] a);
    u_host.xfer({1'b1, a, 8'hFF}, r);
  endtask
  task automatic ev(input int b);
    @(posedge clk);
    evt <= 19'h00001 << b;
    @(posedge clk);
    evt <= '0;
    repeat (3) @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d bad %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #300000;
    err_count++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    evt = '0;
    cfg = SFB_CONFIGURATION_SELECT;
    mode = 1'b0;
    low = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < SFB_NREG; i++) begin
      rd(SFB_ADDR[i], SFB_RST_VAL);
    end
    u_host.xfer(16'h4500, r);
    u_host.xfer(16'h4300, r);
    chk("unmapped", r, 16'hC500);
    rd(7'h43, 8'h02);
    clr(7'h43);
    $display("t1 done");
    ev(18);
    rd(7'h43, 8'h44);
    ev(18);
    ev(18);
    rd(7'h43, 8'h49);
    clr(7'h43);
    rd(7'h43, 8'h08);
    ev(16);
    rd(7'h43, 8'h00);
    @(posedge clk);
    cfg <= SFB_CFG2;
    ev(18);
    ev(18);
    rd(7'h43, 8'h45);
    ev(17);
    ev(18);
    rd(7'h43, 8'h49);
    clr(7'h43);
    ev(16);
    $display("t2 done");
    for (int b = 12; b <= 15; b++) begin
      ev(b);
      rd(7'h43, 8'h40);
      clr(7'h43);
    end
    ev(11);
    rd(7'h43, 8'h80);
    clr(7'h43);
    ev(10);
    ev(9);
    rd(7'h43, 8'h81);
    $display("t3 done");
    for (int b = 8; b >= 6; b--) begin
      ev(b);
      rd(7'h44, {5'h00, 2'(9 - b), 1'b0});
      clr(7'h44);
    end
    @(posedge clk);
    low <= 1'b1;
    rd(7'h44, 8'h00);
    @(posedge clk);
    mode <= 1'b1;
    ev(6);
    low <= 1'b0;
    rd(7'h44, 8'h07);
    chk("txdis", {15'h0000, tx_dis}, 16'h0001);
    for (int b = 5; b >= 2; b--) begin
      ev(b);
    end
    rd(7'h47, 8'h10);
    chk("wkpend", {15'h0000, wk}, 16'h0001);
    ev(0);
    rd(7'h43, 8'h81);
    rd(7'h44, 8'h07);
    rd(7'h46, 8'h31);
    rd(7'h47, 8'h00);
    $display("t4 done");
    ev(1);
    for (int i = 0; i < SFB_NREG; i++) begin
      rd(SFB_ADDR[i], 8'h00);
    end
    $display("t5 done");
    report_and_stop();
  end
endmodule
